// *** hdl/scf_pkg.sv ***
// Purpose: Shared constants and types of the serial command front end
// Assumes: 125 MHz system clock
// Notes:   Character codes, timing and record layouts
package scf_pkg;
  // Clock and link timing
  localparam int CLK_HZ  = 125_000_000;
  localparam int BAUD    = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;  // Clocks per bit
  // Line storage
  localparam int BUF_DEPTH = 128;
  localparam int MNEM_LEN  = 4;
  // Character codes
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_TAB   = 8'h09;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QM    = 8'h3F;
  localparam logic [7:0] CH_UA    = 8'h41;
  localparam logic [7:0] CH_UZ    = 8'h5A;
  // Reset values and event bits
  localparam logic ECHO_RST     = 1'b0;
  localparam int   EVT_OVF_BIT  = 0;
  localparam int   EVT_CMD_BIT  = 1;
  // Query form of a command
  typedef enum logic [1:0] {
    FORM_SET   = 2'h1,
    FORM_QUERY = 2'h2,
    FORM_BOTH  = 2'h3
  } scf_form_t;
  // Syntax class returned for a mnemonic
  typedef struct packed {
    scf_form_t  form;    // Allowed forms
    logic [2:0] req;     // Always required
    logic [2:0] setreq;  // Required to set only
    logic [2:0] opt;     // Optional in both
  } scf_cls_t;
  // Parsed command record
  typedef struct packed {
    logic [31:0] mnem;   // First letter high
    logic        query;  // Question mark seen
    logic [2:0]  nparm;  // Parameter count
  } scf_cmd_t;
  // Parser state codes
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b01,
    ST_PARSE   = 2'b10
  } scf_st_t;
endpackage

// *** hdl/scf_front_end.sv ***
// Purpose: Serial receive, line buffer, command parser, reply sender
// Assumes: rxd_in synchronous to clk_in, cls_in combinational of cmd_out
// Notes on behaviour
// - 9600 baud, no parity, no flow control
// - Echo off after power-on
// - Received bytes kept in 128-byte buffer
// - Parse only after CR or LF
// - Replies sent at once, unbuffered
// - Overflow flushes buffer, flags event status
// - Four-letter mnemonic, uppercase only
// - Question mark after mnemonic means query
// - Set-only rejects query, query-only needs it
// - Braced value: needed to set, illegal query
// - Bracketed value optional in both forms
// - Plain parameters always required
// - Parameters split at commas
// - Semicolons separate commands, run in turn
// - Skip null commands and whitespace
`timescale 1ns/100ps
module scf_front_end #(
  parameter int BIT_CYC_P = scf_pkg::BIT_CYC  // Clocks per bit
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             rxd_in,
  input  wire logic             reply_valid_in,
  input  wire logic [7:0]       reply_byte_in,
  input  wire logic             echo_set_valid_in,
  input  wire logic             echo_set_val_in,
  input  wire logic [7:0]       evt_clr_in,
  input  wire scf_pkg::scf_cls_t cls_in,
  output logic                  txd_out,
  output logic                  reply_ready_out,
  output logic                  cmd_valid_out,
  output logic                  cmd_err_out,
  output scf_pkg::scf_cmd_t     cmd_out,
  output logic                  par_valid_out,
  output logic [7:0]            par_byte_out,
  output logic [2:0]            par_idx_out,
  output logic [7:0]            event_status_register_out,
  output logic                  console_echo_mode_out
);
  import scf_pkg::*;

  // Whole state of the block
  typedef struct packed {
    scf_st_t                     st;
    logic                        rx_act;    // Frame in progress
    logic [15:0]                 rx_cnt;    // Bit timer
    logic [3:0]                  rx_bit;    // Bit index
    logic [7:0]                  rx_sh;     // Data shifter
    logic                        rx_done;   // Byte ready pulse
    logic                        tx_idle;   // Sender free
    logic [15:0]                 tx_cnt;    // Bit timer
    logic [3:0]                  tx_bit;    // Bit index
    logic [8:0]                  tx_sh;     // Data and stop
    logic                        txd;       // Line level
    logic [BUF_DEPTH-1:0][7:0]   lbuf;      // Line storage
    logic [7:0]                  wptr;      // Fill level
    logic [7:0]                  rptr;      // Parse position
    logic                        drop;      // Discard to line end
    logic [2:0]                  mcnt;      // Letters seen
    logic                        qry;       // Query mark seen
    logic [2:0]                  np;        // Parameters seen
    logic                        perr;      // Syntax fault
    logic                        any;       // Command not null
    scf_cmd_t                    cmd;       // Command record
    logic                        cmd_valid; // Good command pulse
    logic                        cmd_err;   // Bad command pulse
    logic                        par_valid; // Parameter byte pulse
    logic [7:0]                  par_byte;  // Parameter byte
    logic [2:0]                  par_idx;   // Parameter number
    logic [7:0]                  evt;       // Event status
    logic                        echo;      // Echo mode
  } scf_state_t;

  scf_state_t s_r;    // Registered state
  scf_state_t s_nxt;  // Next state

  logic [7:0] ch;       // Character under parse
  logic       at_end;   // Line exhausted
  logic       fin;      // Command boundary
  logic [3:0] lo;       // Least parameters
  logic [3:0] hi;       // Most parameters
  logic       bad;      // Command rejected
  logic [7:0] evt_set;  // Events this cycle
  logic       take;     // Reply accepted

  // Uppercase letter test
  function automatic logic is_upper(input logic [7:0] c);
    is_upper = (c >= CH_UA) && (c <= CH_UZ);
  endfunction

  // Line terminator test
  function automatic logic is_term(input logic [7:0] c);
    is_term = (c == CH_CR) || (c == CH_LF);
  endfunction

  // Outputs straight from state
  assign txd_out                   = s_r.txd;
  assign reply_ready_out           = s_r.tx_idle;
  assign cmd_valid_out             = s_r.cmd_valid;
  assign cmd_err_out               = s_r.cmd_err;
  assign cmd_out                   = s_r.cmd;
  assign par_valid_out             = s_r.par_valid;
  assign par_byte_out              = s_r.par_byte;
  assign par_idx_out               = s_r.par_idx;
  assign event_status_register_out = s_r.evt;
  assign console_echo_mode_out     = s_r.echo;

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_done   = 1'b0;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.cmd_err   = 1'b0;
    s_nxt.par_valid = 1'b0;
    evt_set = 8'h00;
    ch      = s_r.lbuf[s_r.rptr[6:0]];
    at_end  = (s_r.rptr == s_r.wptr);
    fin     = at_end || (ch == CH_SEMI);
    // Parameter bounds for the form in use
    lo  = {1'b0, cls_in.req} + (s_r.qry ? 4'h0 : {1'b0, cls_in.setreq});
    hi  = lo + {1'b0, cls_in.opt};
    bad = s_r.perr || (s_r.mcnt != 3'(MNEM_LEN)) ||
          !(cls_in.form inside {FORM_SET, FORM_QUERY, FORM_BOTH}) ||
          (cls_in.form == FORM_SET && s_r.qry) ||
          (cls_in.form == FORM_QUERY && !s_r.qry) ||
          ({1'b0, s_r.np} < lo) || ({1'b0, s_r.np} > hi);
    take = reply_valid_in && s_r.tx_idle;

    // Echo mode update
    if (echo_set_valid_in) begin
      s_nxt.echo = echo_set_val_in;
    end

    // Receiver, 8N1, LSB first
    if (!s_r.rx_act) begin
      if (!rxd_in) begin  // Start edge
        s_nxt.rx_act = 1'b1;
        s_nxt.rx_cnt = 16'(BIT_CYC_P / 2);
        s_nxt.rx_bit = 4'h0;
      end
    end else if (s_r.rx_cnt != 16'h0000) begin
      s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
    end else begin
      s_nxt.rx_cnt = 16'(BIT_CYC_P - 1);
      s_nxt.rx_bit = s_r.rx_bit + 4'h1;
      if (s_r.rx_bit == 4'h0) begin  // Start check
        s_nxt.rx_act = !rxd_in;
      end else if (s_r.rx_bit == 4'h9) begin  // Stop bit
        s_nxt.rx_act  = 1'b0;
        s_nxt.rx_done = rxd_in;
      end else begin
        s_nxt.rx_sh = {rxd_in, s_r.rx_sh[7:1]};
      end
    end

    // Sender: reply first, echo if free
    if (s_r.tx_idle) begin
      if (take || (s_r.rx_done && s_r.echo)) begin
        s_nxt.tx_idle = 1'b0;
        s_nxt.txd     = 1'b0;  // Start bit
        s_nxt.tx_sh   = {1'b1, take ? reply_byte_in : s_r.rx_sh};
        s_nxt.tx_bit  = 4'h0;
        s_nxt.tx_cnt  = 16'(BIT_CYC_P - 1);
      end
    end else if (s_r.tx_cnt != 16'h0000) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
    end else if (s_r.tx_bit == 4'h9) begin  // Stop bit done
      s_nxt.tx_idle = 1'b1;
      s_nxt.txd     = 1'b1;
    end else begin
      s_nxt.txd    = s_r.tx_sh[0];
      s_nxt.tx_sh  = {1'b1, s_r.tx_sh[8:1]};
      s_nxt.tx_bit = s_r.tx_bit + 4'h1;
      s_nxt.tx_cnt = 16'(BIT_CYC_P - 1);
    end

    unique case (s_r.st)
      // Gather bytes until a terminator
      ST_COLLECT: begin
        if (s_r.rx_done) begin
          if (is_term(s_r.rx_sh)) begin
            if (s_r.drop) begin  // Overrun line ends
              s_nxt.drop = 1'b0;
            end else begin
              s_nxt.st   = ST_PARSE;
              s_nxt.rptr = 8'h00;
            end
          end else if (s_r.drop) begin
            s_nxt.drop = 1'b1;  // Still discarding
          end else if (s_r.wptr == 8'(BUF_DEPTH)) begin
            s_nxt.wptr = 8'h00;
            s_nxt.drop = 1'b1;
            evt_set[EVT_OVF_BIT] = 1'b1;
          end else begin
            s_nxt.lbuf[s_r.wptr[6:0]] = s_r.rx_sh;
            s_nxt.wptr = s_r.wptr + 8'h01;
          end
        end
      end
      // Walk the line, one character a cycle
      ST_PARSE: begin
        if (!at_end) begin
          s_nxt.rptr = s_r.rptr + 8'h01;
        end
        if (fin) begin
          if (s_r.any) begin
            if (bad) begin
              s_nxt.cmd_err = 1'b1;
              evt_set[EVT_CMD_BIT] = 1'b1;
            end else begin
              s_nxt.cmd_valid = 1'b1;
              s_nxt.cmd.query = s_r.qry;
              s_nxt.cmd.nparm = s_r.np;
            end
          end
          s_nxt.mcnt = 3'h0;
          s_nxt.qry  = 1'b0;
          s_nxt.np   = 3'h0;
          s_nxt.perr = 1'b0;
          s_nxt.any  = 1'b0;
          if (at_end) begin  // Line done
            s_nxt.st   = ST_COLLECT;
            s_nxt.wptr = 8'h00;
          end
        end else if (ch == CH_SP || ch == CH_TAB) begin
          s_nxt.any = s_r.any;
        end else if (s_r.mcnt != 3'(MNEM_LEN)) begin
          s_nxt.any = 1'b1;
          if (is_upper(ch)) begin
            s_nxt.cmd.mnem = {s_r.cmd.mnem[23:0], ch};
            s_nxt.mcnt     = s_r.mcnt + 3'h1;
          end else begin
            s_nxt.perr = 1'b1;
          end
        end else if (ch == CH_QM) begin
          if (s_r.np == 3'h0 && !s_r.qry) begin
            s_nxt.qry = 1'b1;
          end else begin
            s_nxt.perr = 1'b1;
          end
        end else if (ch == CH_COMMA) begin
          if (s_r.np == 3'h0 || s_r.np == 3'h7) begin
            s_nxt.perr = 1'b1;  // Empty lead or too many
          end else begin
            s_nxt.np = s_r.np + 3'h1;
          end
        end else begin
          // Parameter content byte
          s_nxt.np        = (s_r.np == 3'h0) ? 3'h1 : s_r.np;
          s_nxt.par_valid = 1'b1;
          s_nxt.par_byte  = ch;
          s_nxt.par_idx   = (s_r.np == 3'h0) ? 3'h0 : s_r.np - 3'h1;
        end
      end
    endcase

    // Sticky events, set beats clear
    s_nxt.evt = (s_r.evt & ~evt_clr_in) | evt_set;
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r         <= '0;
      s_r.st      <= ST_COLLECT;
      s_r.tx_idle <= 1'b1;
      s_r.txd     <= 1'b1;
      s_r.echo    <= ECHO_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Echo only rises on an explicit request
  AST_ECHO_OFF: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(s_r.echo) |-> $past(echo_set_valid_in && echo_set_val_in))
    else $error("echo mode rose without request");

  // Fill never passes the buffer size
  AST_BUF_SIZE: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    s_r.wptr <= 8'(BUF_DEPTH))
    else $error("line buffer fill out of range");

  // Parsing starts only on a terminator
  AST_PARSE_ON_EOL: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s_r.st == ST_COLLECT) ##1 (s_r.st == ST_PARSE) |->
      $past(s_r.rx_done && is_term(s_r.rx_sh)))
    else $error("parse began without terminator");

  // Reply taken starts a frame at once
  AST_REPLY_START: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (reply_valid_in && reply_ready_out) |=> (!txd_out && !reply_ready_out)[*2])
    else $error("reply not sent at once");

  // Overflow flushes and flags
  AST_OVF_FLUSH: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (s_r.st == ST_COLLECT && s_r.rx_done && !s_r.drop &&
     !is_term(s_r.rx_sh) && s_r.wptr == 8'(BUF_DEPTH)) |=>
      (s_r.wptr == 8'h00 && s_r.drop && s_r.evt[EVT_OVF_BIT]))
    else $error("overflow not flushed");

  // Accepted mnemonics are uppercase
  AST_UPPER: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    cmd_valid_out |-> (is_upper(cmd_out.mnem[31:24]) && is_upper(cmd_out.mnem[23:16]) &&
                       is_upper(cmd_out.mnem[15:8]) && is_upper(cmd_out.mnem[7:0])))
    else $error("lowercase mnemonic accepted");

  // Set-only never yields a query
  AST_SET_ONLY: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (cmd_valid_out && cls_in.form == FORM_SET) |-> !cmd_out.query)
    else $error("query of set-only command accepted");

  // Required parameters present
  AST_REQ_PARMS: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    cmd_valid_out |-> (cmd_out.nparm >= cls_in.req))
    else $error("missing required parameter");

  // Error pulse also flags event status
  AST_CMD_ERR: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    cmd_err_out |-> (event_status_register_out[EVT_CMD_BIT] && !cmd_valid_out))
    else $error("command error not flagged");

endmodule // scf_front_end

// *** verification/scf_host_model.sv ***
// Purpose: Host computer on the serial link of the front end
// Assumes: 8 data bits, no parity, one stop, LSB first
// Notes:   Line idles high between frames
`timescale 1ns/100ps
module scf_host_model #(
  parameter int BIT_P = 16  // Clocks per bit
) (
  input  wire logic clk_in,
  output logic      rxd_out,  // Into the device
  input  wire logic txd_in    // From the device
);
  logic [7:0] rx_byte = 8'h00;  // Last byte heard
  int         rx_cnt  = 0;      // Bytes heard
  initial rxd_out = 1'b1;  // Idle mark
  // Send one frame, start, data LSB first, stop; no parity, no handshake
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      rxd_out = f[i];
      repeat (BIT_P - 1) @(negedge clk_in);
    end
  endtask
  // Decode frames sent by the device, mid-bit sampling
  initial begin
    forever begin
      @(negedge txd_in);
      repeat (BIT_P / 2) @(posedge clk_in);
      if (txd_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_P) @(posedge clk_in);
          rx_byte[i] = txd_in;
        end
        repeat (BIT_P) @(posedge clk_in);
        if (txd_in === 1'b1) rx_cnt++;  // Stop bit seen
      end
    end
  end
endmodule // scf_host_model

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the serial command front end
// Assumes: Shortened bit time, host model on the serial pins
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/100ps
module tb;
  import scf_pkg::*;
  localparam int BIT = 16;  // Shortened bit time
  logic       clk_in, resetn_in, rxd, txd, reply_valid, reply_ready;
  logic       echo_set_valid, echo_set_val, cmd_valid, cmd_err, par_valid, echo;
  logic [7:0] reply_byte, evt_clr, par_byte, evt, last_par;
  logic [2:0] par_idx, last_idx;
  scf_cls_t   cls;
  scf_cmd_t   cmd, last_cmd;
  int         mismatches = 0, n_checks = 0, n_ok = 0, n_err = 0;
  // Clock source
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  scf_front_end #(.BIT_CYC_P(BIT)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .rxd_in(rxd),
    .reply_valid_in(reply_valid), .reply_byte_in(reply_byte),
    .echo_set_valid_in(echo_set_valid), .echo_set_val_in(echo_set_val),
    .evt_clr_in(evt_clr), .cls_in(cls), .txd_out(txd),
    .reply_ready_out(reply_ready), .cmd_valid_out(cmd_valid),
    .cmd_err_out(cmd_err), .cmd_out(cmd), .par_valid_out(par_valid),
    .par_byte_out(par_byte), .par_idx_out(par_idx),
    .event_status_register_out(evt), .console_echo_mode_out(echo));
  scf_host_model #(.BIT_P(BIT)) host_u (.clk_in(clk_in), .rxd_out(rxd), .txd_in(txd));
  // Syntax classes of the mnemonics used here
  always_comb begin
    cls = '0;
    case (cmd.mnem)
      32'h4D414E53: cls = '{FORM_BOTH, 3'h0, 3'h1, 3'h0};  // Braced value
      32'h54444945: cls.form = FORM_QUERY;                // Query only
      32'h50414952: cls = '{FORM_SET, 3'h2, 3'h0, 3'h0};  // Two plain values
      32'h4F505456: cls = '{FORM_BOTH, 3'h0, 3'h0, 3'h1};  // Bracketed value
      default: cls = '0;
    endcase
  end
  // Count verdicts, keep last command and parameter; falling edge, away from launch
  always @(negedge clk_in) begin
    if (cmd_valid === 1'b1) begin
      n_ok++;
      last_cmd = cmd;
    end
    if (cmd_err === 1'b1) n_err++;
    if (par_valid === 1'b1) begin
      last_par = par_byte;
      last_idx = par_idx;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) host_u.send_byte(s[i]);
  endtask
  // Send a line, let parsing end, compare verdict counts
  task automatic run_line(input string s, input int ok, input int err);
    int ok0, err0;
    ok0 = n_ok;
    err0 = n_err;
    send_str(s);
    repeat (140) @(negedge clk_in);
    chk("good count", n_ok - ok0, ok);
    chk("error count", n_err - err0, err);
  endtask
  task automatic clear_evt();
    evt_clr = 8'hFF;
    @(negedge clk_in);
    evt_clr = 8'h00;
    @(negedge clk_in);
    chk("events cleared", evt, 0);
  endtask
  task automatic set_echo(input logic v);
    echo_set_val = v;
    echo_set_valid = 1'b1;
    @(negedge clk_in);
    echo_set_valid = 1'b0;
    @(negedge clk_in);
    chk("echo mode", echo, v);
  endtask
  task automatic t_reset();
    chk("txd idle", txd, 1);
    chk("reply ready", reply_ready, 1);
    chk("echo after reset", echo, 0);
    chk("events after reset", evt, 0);
  endtask
  task automatic t_set();
    int ok0;
    ok0 = n_ok;
    send_str("MANS 5");
    repeat (300) @(negedge clk_in);
    chk("held before end", n_ok - ok0, 0);
    run_line("\r", 1, 0);
    chk("mnemonic", last_cmd.mnem, 32'h4D414E53);
    chk("set form", last_cmd.query, 0);
    chk("param count", last_cmd.nparm, 1);
    chk("param byte", last_par, 8'h35);
  endtask
  task automatic t_forms();
    run_line("MANS?;mans 1;; ; T DIE ?;TDIE;MANS?5\n", 2, 3);
    chk("query mnemonic", last_cmd.mnem, 32'h54444945);
    chk("query form", last_cmd.query, 1);
    chk("error flag", evt[EVT_CMD_BIT], 1);
    clear_evt();
  endtask
  task automatic t_params();
    run_line("PAIR 1 , 2\r", 1, 0);
    chk("two params", last_cmd.nparm, 2);
    chk("last param", last_par, 8'h32);
    chk("last param index", last_idx, 3'h1);
    run_line("PAIR 7;PAIR?1,2\r", 0, 2);
  endtask
  // Optional value in both forms, missing braced value, unknown mnemonic
  task automatic t_opt();
    run_line("OPTV;OPTV?;OPTV 3;OPTV?3;OPTV 3,4;MANS\r", 4, 2);
    chk("optional count", last_cmd.nparm, 1);
    chk("optional query", last_cmd.query, 1);
    run_line("ABCD?\r", 0, 1);
    chk("unknown flagged", evt[EVT_CMD_BIT], 1);
    clear_evt();
  endtask
  task automatic t_fill();
    send_str("TDIE?");
    repeat (123) host_u.send_byte(8'h20);
    run_line("\r", 1, 0);
    chk("no overflow", evt[EVT_OVF_BIT], 0);
    repeat (129) host_u.send_byte(8'h20);
    run_line("TDIE?\r", 0, 0);
    chk("overflow flag", evt[EVT_OVF_BIT], 1);
    run_line("TDIE?\r", 1, 0);
    clear_evt();
  endtask
  // Offer one reply byte and follow it onto the wire
  task automatic send_reply(input logic [7:0] b);
    int c0;
    c0 = host_u.rx_cnt;
    reply_byte = b;
    reply_valid = 1'b1;
    @(negedge clk_in);
    reply_valid = 1'b0;
    @(negedge clk_in);
    chk("sender busy", reply_ready, 0);
    chk("start bit", txd, 0);
    repeat (9 * BIT - 2) @(negedge clk_in);
    chk("busy for frame", reply_ready, 0);
    for (int i = 0; i < 2 * BIT && reply_ready !== 1'b1; i++) @(negedge clk_in);
    chk("bytes heard", host_u.rx_cnt - c0, 1);
    chk("reply byte", host_u.rx_byte, b);
  endtask
  task automatic t_echo();
    int c0;
    set_echo(1'b1);
    c0 = host_u.rx_cnt;
    host_u.send_byte(8'h20);
    for (int i = 0; i < 12 * BIT && host_u.rx_cnt == c0; i++) @(negedge clk_in);
    chk("echoed byte", host_u.rx_byte, 8'h20);
    set_echo(1'b0);
    c0 = host_u.rx_cnt;
    run_line("\r", 0, 0);
    chk("no echo", host_u.rx_cnt - c0, 0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence, inputs change at falling edges
  initial begin
    resetn_in = 1'b0;
    reply_valid = 1'b0;
    reply_byte = 8'h00;
    echo_set_valid = 1'b0;
    echo_set_val = 1'b0;
    evt_clr = 8'h00;
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    t_reset();
    t_set();
    t_forms();
    t_params();
    t_opt();
    t_fill();
    send_reply(8'hA5);
    send_reply(8'h3C);
    t_echo();
    complete_run();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (90000) @(posedge clk_in);
    mismatches++;
    complete_run();
  end
endmodule // tb
